/* common/pmx_pkg.sv */
// Package of constants and carrier types for the pin mode multiplexer.
package pmx_pkg;

  // Mode-select strap positions inside the four-bit strap vector.
  localparam int MODE_A_BIT = 0;
  localparam int MODE_B_BIT = 1;
  localparam int MODE_C_BIT = 2;
  localparam int MODE_D_BIT = 3;

  // Widths of the external buses.
  localparam int EXT_ADDR_W  = 14;
  localparam int EXT_DATA_W  = 24;
  localparam int HOST_AD_W   = 16;
  localparam int FLAG_W      = 8;
  localparam int BYTE_ADDR_W = 8;

  // Register offsets on the APB (byte addresses, own choice).
  localparam logic [7:0] OFF_SYSCTL  = 8'h00;
  localparam logic [7:0] OFF_FLAGDIR = 8'h04;
  localparam logic [7:0] OFF_FLAGOUT = 8'h08;
  localparam logic [7:0] OFF_FLAGIN  = 8'h0C;
  localparam logic [7:0] OFF_STRAPS  = 8'h10;
  localparam logic [7:0] OFF_ISTAT   = 8'h14;
  localparam logic [7:0] OFF_IEN     = 8'h18;
  localparam logic [7:0] OFF_ICLR    = 8'h1C;
  localparam logic [7:0] OFF_MEMREQ  = 8'h20;
  localparam logic [7:0] OFF_MEMDAT  = 8'h24;

  // System control fields.
  localparam int SYSCTL_SPB_ALT  = 0;  // 1: serial port B pins are irqs/flags
  localparam int SYSCTL_SENS_LO  = 1;  // bits 3:1 edge select: ext, alt0, alt1
  localparam int SYSCTL_GO_MODE  = 4;
  localparam int SYSCTL_FOUT     = 5;  // alternate flag output level

  // Interrupt status bit positions.
  localparam int IRQ_EXT   = 0;
  localparam int IRQ_LVB   = 1;
  localparam int IRQ_LVA   = 2;
  localparam int IRQ_EDGE  = 3;
  localparam int IRQ_ALT0  = 4;
  localparam int IRQ_ALT1  = 5;
  localparam int IRQ_N     = 6;

  // Reset values.
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // Interface mode chosen by the Mode C strap.
  typedef enum logic [0:0]
  {
    PMX_FULL_MEM = 1'b0,
    PMX_HOST     = 1'b1
  } pmx_mode_t;

  // Bus grant state.
  typedef enum logic [1:0]
  {
    PMX_BUS_OWN   = 2'b00,
    PMX_BUS_GRANT = 2'b01
  } pmx_bus_t;

  // Two-way pin carrier: output and output enable.
  typedef struct packed
  {
    logic [EXT_DATA_W-1:0] o;
    logic [EXT_DATA_W-1:0] oe;
  } pmx_data_drv_t;

endpackage : pmx_pkg

/* rtl/pmx_dsp_pin_mode_mux.sv */
// Pin multiplexer and boot-mode selector with an APB register file.
// Contract
// - External bus pin roles are fixed only during reset, never reassigned.
// - Serial port pin roles may be changed by software at any time.
// - Shared interrupt and flag pins keep both functions simultaneously.
// - Enabled interrupt fires when shared pin asserts, from outside or own flag, except own flag 7 while ext is edge-sensitive.
// - Mode pins sampled only in reset; afterwards they are flag lines.
// - Mode C low selects full memory mode, high host mode, until reset.
// - Full mode offers byte transfers and overlay; host mode offers host port. No overlay logic is implemented here.
// - Full mode drives 14-bit address, 24-bit data; top byte adds address.
// - Host mode gives 16-bit host bus; host strobes in, acknowledge out.
// - Host mode drives only low address bit and upper sixteen data lines.
// - Host acknowledge is open drain, behaviour set by Mode D strap.
// - A system control field picks serial or irq/flag roles for port B.
// - Ext and alt irqs selectable edge/level; level irqs level, edge irq edge.
// - Outside master requests buses; normal mode halts, go mode keeps running.
`timescale 1ns/1ps
`default_nettype none
module pmx_dsp_pin_mode_mux
  import pmx_pkg::*;
(
  // Clock and reset.
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave.
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Shared programmable flag lines, mode straps on the low four.
  input  wire logic [pmx_pkg::FLAG_W-1:0] prog_flag_lines_i,
  output logic      [pmx_pkg::FLAG_W-1:0] prog_flag_lines_o,
  output logic      [pmx_pkg::FLAG_W-1:0] prog_flag_lines_oe,
  // Dedicated interrupt pin, active low.
  input  wire logic                     ext_irq_config,
  // Serial port B pins: serial data or alternate irqs and flags.
  input  wire logic                     spb_rx_i,
  input  wire logic                     spb_rfs_i,
  input  wire logic                     spb_tfs_i,
  output logic                          spb_tx_o,
  input  wire logic                     core_spb_tx,
  output logic                          spb_rx_core,
  output logic                          serial_alt_flag_in,
  // External memory bus.
  output logic      [pmx_pkg::EXT_ADDR_W-1:0] ext_addr_bus,
  input  wire logic [pmx_pkg::EXT_DATA_W-1:0] ext_data_bus_i,
  output logic      [pmx_pkg::EXT_DATA_W-1:0] ext_data_bus_o,
  output logic      [pmx_pkg::EXT_DATA_W-1:0] ext_data_bus_oe,
  output logic                          byte_space_select_n,
  output logic                          io_space_select_n,
  output logic                          combined_space_select_n,
  // Bus arbitration.
  input  wire logic                     bus_request_n,
  output logic                          bus_grant_n,
  output logic                          bus_grant_hung_n,
  output logic                          core_halt,
  // Host access port.
  input  wire logic [pmx_pkg::HOST_AD_W-1:0] host_addr_data_bus_i,
  output logic      [pmx_pkg::HOST_AD_W-1:0] host_addr_data_bus_o,
  output logic      [pmx_pkg::HOST_AD_W-1:0] host_addr_data_bus_oe,
  input  wire logic                     host_write_n,
  input  wire logic                     host_read_n,
  input  wire logic                     host_addr_latch,
  input  wire logic                     host_select_n,
  output logic                          host_ack_n_o,
  output logic                          host_ack_n_oe,
  // Status and interrupt.
  output logic                          mode_host,
  output logic                          irq
);
  import pmx_pkg::*;

  // Two-flop synchronisers for the pins from outside the clock domain, except spb_rx_i, which is registered once.
  logic [FLAG_W-1:0]     pf_s1_r, pf_s2_r;
  logic [4:0]            irq_s1_r, irq_s2_r, irq_d_r;
  logic                  br_s1_r, br_s2_r;
  logic [EXT_DATA_W-1:0] d_s1_r, d_s2_r;
  logic [HOST_AD_W-1:0]  ad_s1_r, ad_s2_r;
  logic [3:0]            hs_s1_r, hs_s2_r;
  logic [4:0]            irq_raw;
  logic                  pf_prev_r4;

  // Raw active-low interrupt inputs: alt0, alt1, two spare, ext.
  always_comb
  begin
    irq_raw = {spb_rfs_i, spb_tfs_i, 2'h3, ext_irq_config};
  end

  // Flag pads are synchronised through reset so the straps are settled
  // at release; these flops need no reset value.
  always_ff @(posedge pclk)
  begin
    pf_s1_r <= prog_flag_lines_i;
    pf_s2_r <= pf_s1_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_s1_r <= 5'h1F;
      irq_s2_r <= 5'h1F;
      irq_d_r  <= 5'h1F;
      br_s1_r  <= 1'b1;
      br_s2_r  <= 1'b1;
      d_s1_r   <= '0;
      d_s2_r   <= '0;
      ad_s1_r  <= '0;
      ad_s2_r  <= '0;
      hs_s1_r  <= 4'hF;
      hs_s2_r  <= 4'hF;
    end
    else
    begin
      irq_s1_r <= irq_raw;
      irq_s2_r <= irq_s1_r;
      irq_d_r  <= irq_s2_r;
      br_s1_r  <= bus_request_n;
      br_s2_r  <= br_s1_r;
      d_s1_r   <= ext_data_bus_i;
      d_s2_r   <= d_s1_r;
      ad_s1_r  <= host_addr_data_bus_i;
      ad_s2_r  <= ad_s1_r;
      hs_s1_r  <= {host_write_n, host_read_n, ~host_addr_latch,
                   host_select_n};
      hs_s2_r  <= hs_s1_r;
    end
  end

  // Strap capture. The async reset loads a constant; the pins are taken
  // on the first clock after release and then frozen until next reset.
  logic       strap_done_r;
  logic [3:0] straps_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_done_r <= 1'b0;
      straps_r     <= 4'h0;
    end
    else if (!strap_done_r)
    begin
      strap_done_r <= 1'b1;
      straps_r     <= pf_s2_r[3:0];
    end
  end

  // Interface mode follows Mode C and never changes after capture.
  pmx_mode_t mode_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_r <= PMX_FULL_MEM;
    else if (!strap_done_r)
      mode_r <= pmx_mode_t'(pf_s2_r[MODE_C_BIT]);
  end

  // Software registers.
  logic [5:0]        sysctl_r;
  logic [FLAG_W-1:0] flag_dir_r, flag_out_r;
  logic [IRQ_N-1:0]  istat_r, ien_r;
  logic [21:0]       mem_addr_r;
  logic [EXT_DATA_W-1:0] mem_wdat_r;
  logic              mem_go_r, mem_wr_r, mem_byte_r, mem_io_r;
  logic              wr_en, rd_en;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // Control writes; serial port role may change at any time.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sysctl_r   <= '0;
      flag_dir_r <= '0;
      flag_out_r <= '0;
      ien_r      <= '0;
      mem_addr_r <= '0;
      mem_wdat_r <= '0;
      mem_wr_r   <= 1'b0;
      mem_byte_r <= 1'b0;
      mem_io_r   <= 1'b0;
    end
    else if (wr_en)
    begin
      case (paddr)
        OFF_SYSCTL:  sysctl_r   <= pwdata[5:0];
        OFF_FLAGDIR: flag_dir_r <= pwdata[FLAG_W-1:0];
        OFF_FLAGOUT: flag_out_r <= pwdata[FLAG_W-1:0];
        OFF_IEN:     ien_r      <= pwdata[IRQ_N-1:0];
        OFF_MEMREQ:
        begin
          mem_addr_r <= pwdata[21:0];
          mem_wr_r   <= pwdata[29];
          mem_io_r   <= pwdata[30];
          mem_byte_r <= pwdata[31];
        end
        OFF_MEMDAT:  mem_wdat_r <= pwdata[EXT_DATA_W-1:0];
        default:     ;
      endcase
    end
  end

  // Flag pin levels as seen on the pad, own drive included.
  logic [FLAG_W-1:0] pf_level;
  assign pf_level = strap_done_r ? pf_s2_r : '0;

  // Interrupt detection. Pins 7:4 keep flag and interrupt roles at once.
  logic [IRQ_N-1:0] ev;
  logic             alt;
  logic [2:0]       edge_sel;
  assign alt      = sysctl_r[SYSCTL_SPB_ALT];
  assign edge_sel = sysctl_r[SYSCTL_SENS_LO+2:SYSCTL_SENS_LO];
  always_comb
  begin
    ev = '0;
    // Interrupt pins are low-active; flag drive reaches them via the pad, except pin 7 while ext is edge-sensitive.
    ev[IRQ_EXT]  = edge_sel[0] ? (irq_d_r[0] &&
                   !irq_s2_r[0]) || (!pf_level[7] && !flag_dir_r[7])
                   : !irq_s2_r[0] || (strap_done_r && !pf_level[7]);
    ev[IRQ_LVB]  = strap_done_r && !pf_level[6];
    ev[IRQ_LVA]  = strap_done_r && !pf_level[5];
    ev[IRQ_EDGE] = strap_done_r && !pf_level[4] && pf_s2_r[4] == 1'b0
                   && pf_prev_r4;
    ev[IRQ_ALT0] = alt && (edge_sel[1] ? (irq_d_r[4] && !irq_s2_r[4])
                   : !irq_s2_r[4]);
    ev[IRQ_ALT1] = alt && (edge_sel[2] ? (irq_d_r[3] && !irq_s2_r[3])
                   : !irq_s2_r[3]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pf_prev_r4 <= 1'b1;
    else
      pf_prev_r4 <= !strap_done_r || pf_s2_r[4];
  end

  // Sticky status: a set in the same cycle as a clear wins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      istat_r <= '0;
    else if (wr_en && paddr == OFF_ICLR)
      istat_r <= (istat_r & ~pwdata[IRQ_N-1:0]) | ev;
    else
      istat_r <= istat_r | ev;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(istat_r & ien_r);
  end

  // Flag pin drivers; the mode straps are ordinary flags once captured.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prog_flag_lines_o  <= '0;
      prog_flag_lines_oe <= '0;
    end
    else
    begin
      prog_flag_lines_o  <= flag_out_r;
      prog_flag_lines_oe <= strap_done_r ? flag_dir_r : '0;
    end
  end

  // Serial port B pin steering.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      spb_tx_o           <= 1'b0;
      spb_rx_core        <= 1'b0;
      serial_alt_flag_in <= 1'b0;
    end
    else
    begin
      spb_tx_o    <= alt ? sysctl_r[SYSCTL_FOUT] : core_spb_tx;
      spb_rx_core <= alt ? 1'b0 : spb_rx_i;
      serial_alt_flag_in <= alt ? spb_rx_i : 1'b0;
    end
  end

  // Bus arbitration: grant while requested; normal mode halts the core.
  pmx_bus_t bus_r;
  logic     ext_busy;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_r            <= PMX_BUS_OWN;
      bus_grant_n      <= 1'b1;
      bus_grant_hung_n <= 1'b1;
      core_halt        <= 1'b0;
    end
    else
    begin
      case (bus_r)
        PMX_BUS_OWN:
          if (!br_s2_r && !mem_go_r)
          begin
            bus_r       <= PMX_BUS_GRANT;
            bus_grant_n <= 1'b0;
            core_halt   <= !sysctl_r[SYSCTL_GO_MODE];
          end
        PMX_BUS_GRANT:
        begin
          bus_grant_hung_n <= !(ext_busy && sysctl_r[SYSCTL_GO_MODE]);
          if (br_s2_r)
          begin
            bus_r            <= PMX_BUS_OWN;
            bus_grant_n      <= 1'b1;
            bus_grant_hung_n <= 1'b1;
            core_halt        <= 1'b0;
          end
        end
        default: bus_r <= PMX_BUS_OWN;
      endcase
    end
  end
  assign ext_busy = wr_en && paddr == OFF_MEMREQ;

  // External access engine, one cycle per strobe; drives pins by mode.
  logic [EXT_DATA_W-1:0] mem_rdat_r;
  logic                  own_bus;
  assign own_bus = bus_r == PMX_BUS_OWN;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_go_r                <= 1'b0;
      ext_addr_bus            <= '0;
      ext_data_bus_o          <= '0;
      ext_data_bus_oe         <= '0;
      byte_space_select_n     <= 1'b1;
      io_space_select_n       <= 1'b1;
      combined_space_select_n <= 1'b1;
    end
    else if (ext_busy && own_bus && strap_done_r)
    begin
      mem_go_r <= 1'b1;
    end
    else if (mem_go_r)
    begin
      mem_go_r <= 1'b0;
      if (mode_r == PMX_FULL_MEM)
      begin
        // Full address; byte space borrows the top data byte.
        ext_addr_bus    <= mem_addr_r[EXT_ADDR_W-1:0];
        ext_data_bus_o  <= mem_byte_r
          ? {mem_addr_r[21:14], mem_wdat_r[15:0]} : mem_wdat_r;
        ext_data_bus_oe <= mem_byte_r ? {8'hFF, {16{mem_wr_r}}}
                                      : {24{mem_wr_r}};
        byte_space_select_n <= !mem_byte_r;
      end
      else
      begin
        // Only the low address bit; upper sixteen data lines carry data.
        ext_addr_bus    <= {13'h0000, mem_addr_r[0]};
        ext_data_bus_o  <= {mem_wdat_r[15:0], 8'h00};
        ext_data_bus_oe <= {{16{mem_wr_r}}, 8'h00};
        byte_space_select_n <= 1'b1;
      end
      io_space_select_n       <= !mem_io_r;
      combined_space_select_n <= mem_io_r || mem_byte_r;
    end
    else
    begin
      ext_data_bus_oe         <= '0;
      byte_space_select_n     <= 1'b1;
      io_space_select_n       <= 1'b1;
      combined_space_select_n <= 1'b1;
    end
  end

  // Read data crosses the pad synchroniser, so it is taken three cycles
  // after the strobe edge, when the settled copy holds the memory word.
  logic [2:0] rd_cap_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_cap_r   <= 3'h0;
      mem_rdat_r <= '0;
    end
    else
    begin
      rd_cap_r <= {rd_cap_r[1:0], mem_go_r && !mem_wr_r};
      if (rd_cap_r[2])
        mem_rdat_r <= d_s2_r;
    end
  end

  // Host access port: latch address, echo it on reads, acknowledge.
  logic [HOST_AD_W-1:0] host_addr_r;
  logic                 host_act;
  assign host_act = mode_r == PMX_HOST && strap_done_r && !hs_s2_r[0];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      host_addr_r           <= '0;
      host_addr_data_bus_o  <= '0;
      host_addr_data_bus_oe <= '0;
      host_ack_n_o          <= 1'b0;
      host_ack_n_oe         <= 1'b0;
    end
    else
    begin
      if (host_act && !hs_s2_r[1])
        host_addr_r <= ad_s2_r;
      host_addr_data_bus_o  <= host_addr_r;
      host_addr_data_bus_oe <= {HOST_AD_W{host_act && !hs_s2_r[2]}};
      // Open drain: only ever pulls low. Mode D low acks while selected,
      // Mode D high acks only on a strobe.
      host_ack_n_o  <= 1'b0;
      host_ack_n_oe <= host_act && (!straps_r[MODE_D_BIT] ||
                       !hs_s2_r[2] || !hs_s2_r[3]);
    end
  end

  // APB read path and handshake; ready on the access cycle, no waits.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= RST_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr > OFF_MEMDAT;
      if (rd_en)
      begin
        case (paddr)
          OFF_SYSCTL:  prdata <= {26'h0, sysctl_r};
          OFF_FLAGDIR: prdata <= {24'h0, flag_dir_r};
          OFF_FLAGOUT: prdata <= {24'h0, flag_out_r};
          OFF_FLAGIN:  prdata <= {24'h0, pf_level};
          OFF_STRAPS:  prdata <= {27'h0, mode_r, straps_r};
          OFF_ISTAT:   prdata <= {26'h0, istat_r};
          OFF_IEN:     prdata <= {26'h0, ien_r};
          OFF_MEMDAT:  prdata <= {8'h00, mem_rdat_r};
          default:     prdata <= RST_ZERO;
        endcase
      end
    end
  end

  assign mode_host = mode_r == PMX_HOST;

endmodule : pmx_dsp_pin_mode_mux
`default_nettype wire

/* dv/pmx_checker.sv */
// Concurrent checks on the ports of the pin mode multiplexer.
`timescale 1ns/1ps
`default_nettype none
module pmx_checker
  import pmx_pkg::*;
(
  // Clock and reset.
  input wire logic                           pclk,
  input wire logic                           presetn,
  // APB.
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic [7:0]                     paddr,
  input wire logic                           pready,
  input wire logic                           pslverr,
  // Pins.
  input wire logic [pmx_pkg::FLAG_W-1:0]     prog_flag_lines_oe,
  input wire logic [pmx_pkg::EXT_ADDR_W-1:0] ext_addr_bus,
  input wire logic [pmx_pkg::EXT_DATA_W-1:0] ext_data_bus_oe,
  input wire logic                           byte_space_select_n,
  input wire logic                           io_space_select_n,
  input wire logic                           bus_grant_n,
  input wire logic                           host_ack_n_o,
  input wire logic                           host_ack_n_oe,
  input wire logic                           mode_host
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [2:0] age_r;

  // Cycles since reset release; the strap capture is over well before four.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      age_r <= 3'h0;
    else if (age_r != 3'h4)
      age_r <= age_r + 3'h1;
  end

  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready one cycle after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  unmapped_err_a: assert property (pready && paddr > 8'h24 |-> pslverr)
    else $error("unmapped offset without slave error");
  mode_hold_a: assert property (age_r == 3'h4 |-> $stable(mode_host))
    else $error("interface mode changed after reset");
  strap_quiet_a: assert property (age_r == 3'h0 |-> prog_flag_lines_oe == '0)
    else $error("flag line driven before strap capture");
  ack_drain_a: assert property (host_ack_n_o == 1'b0)
    else $error("acknowledge pin drives high");
  ack_host_a: assert property (host_ack_n_oe |-> mode_host)
    else $error("acknowledge outside host mode");
  host_pins_a: assert property (mode_host |-> ext_addr_bus[13:1] == '0
    && ext_data_bus_oe[7:0] == '0)
    else $error("host mode drives more than low address bit");
  byte_full_a: assert property (!byte_space_select_n |-> !mode_host)
    else $error("byte access in host mode");
  grant_free_a: assert property (!bus_grant_n |-> ext_data_bus_oe == '0)
    else $error("data bus driven while granted");

  // Main scenarios reached by the bench.
  grant_c: cover property (!bus_grant_n);
  host_ack_c: cover property (mode_host && host_ack_n_oe);
  io_c: cover property (!io_space_select_n);
endmodule : pmx_checker

bind pmx_dsp_pin_mode_mux pmx_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .prog_flag_lines_oe(prog_flag_lines_oe), .ext_addr_bus(ext_addr_bus),
  .ext_data_bus_oe(ext_data_bus_oe),
  .byte_space_select_n(byte_space_select_n),
  .io_space_select_n(io_space_select_n), .bus_grant_n(bus_grant_n),
  .host_ack_n_o(host_ack_n_o), .host_ack_n_oe(host_ack_n_oe),
  .mode_host(mode_host)
);
`default_nettype wire

/* dv/pmx_ext_mem.sv */
// Behavioural external I/O memory on the far side of the bus.
`timescale 1ns/1ps
`default_nettype none
module pmx_ext_mem
  import pmx_pkg::*;
(
  // Clock.
  input  wire logic                           pclk,
  // Device side of the memory bus.
  input  wire logic [pmx_pkg::EXT_ADDR_W-1:0] addr,
  input  wire logic [pmx_pkg::EXT_DATA_W-1:0] d_o,
  input  wire logic [pmx_pkg::EXT_DATA_W-1:0] d_oe,
  input  wire logic                           io_sel_n,
  output logic      [pmx_pkg::EXT_DATA_W-1:0] d_i
);
  logic [EXT_DATA_W-1:0] mem [16];
  logic [EXT_DATA_W-1:0] last = '0;
  logic                  rd_en;

  // Decode from the select, the data drive enables and the low address lines.
  assign rd_en = !io_sel_n && (d_oe == '0);
  // A released bus shows the inverse of its last value, so stale data fails.
  assign d_i = rd_en ? mem[addr[3:0]] : ~last;

  // Writes are taken while the device selects and drives any data line.
  always @(posedge pclk)
  begin
    if (!io_sel_n && d_oe != '0)
      mem[addr[3:0]] <= d_o;
    last <= d_i;
  end
endmodule : pmx_ext_mem
`default_nettype wire

/* dv/tb_dsp_pin_mode_mux.sv */
// Self-checking bench for the pin mode multiplexer.
`timescale 1ns/1ps
`default_nettype none
module tb_dsp_pin_mode_mux;
  import pmx_pkg::*;
  typedef struct packed {logic [31:0] v; logic [31:0] m; logic e;} pmx_exp_t;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, tx, rxc, afi, bsel_n, iosel_n, csel_n;
  logic [7:0]  pf_drv = 8'hF0;
  logic [7:0]  pf_pin, pf_o, pf_oe;
  logic        eirq_n = 1'b1;
  logic        rx = 1'b0;
  logic        rfs_n = 1'b1;
  logic        ctx = 1'b0;
  logic        breq_n = 1'b1;
  logic        hsel_n = 1'b1;
  logic        bg_n, bgh_n, halt, ack_o, ack_oe, mhost, irq;
  logic [13:0] ea;
  logic [23:0] ed_i, ed_o, ed_oe;
  logic [15:0] had_o, had_oe;
  logic [31:0] d;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  int          seed = 32'hf141d5a7;
  pmx_exp_t    q[$];

  // Flag pins: the device's own drive wins over the outside driver.
  assign pf_pin = (pf_oe & pf_o) | (~pf_oe & pf_drv);

  pmx_dsp_pin_mode_mux dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog_flag_lines_i(pf_pin),
    .prog_flag_lines_o(pf_o), .prog_flag_lines_oe(pf_oe),
    .ext_irq_config(eirq_n), .spb_rx_i(rx), .spb_rfs_i(rfs_n),
    .spb_tfs_i(1'b0), .spb_tx_o(tx), .core_spb_tx(ctx), .spb_rx_core(rxc),
    .serial_alt_flag_in(afi), .ext_addr_bus(ea), .ext_data_bus_i(ed_i),
    .ext_data_bus_o(ed_o), .ext_data_bus_oe(ed_oe),
    .byte_space_select_n(bsel_n), .io_space_select_n(iosel_n),
    .combined_space_select_n(csel_n), .bus_request_n(breq_n),
    .bus_grant_n(bg_n), .bus_grant_hung_n(bgh_n), .core_halt(halt),
    .host_addr_data_bus_i(16'h0000), .host_addr_data_bus_o(had_o),
    .host_addr_data_bus_oe(had_oe), .host_write_n(1'b1),
    .host_read_n(1'b1), .host_addr_latch(1'b0), .host_select_n(hsel_n),
    .host_ack_n_o(ack_o), .host_ack_n_oe(ack_oe), .mode_host(mhost),
    .irq(irq));

  pmx_ext_mem u_mem (.pclk(pclk), .addr(ea), .d_o(ed_o), .d_oe(ed_oe),
    .io_sel_n(iosel_n), .d_i(ed_i));

  always #50 pclk = ~pclk;

  // A hung run is cut short well beyond the expected length.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task automatic chk_pin(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %0t pin got %h exp %h", $time, g, e);
    end
  endtask : chk_pin

  task automatic chk_reg(input pmx_exp_t e);
    checked++;
    if ((prdata & e.m) !== e.v || pslverr !== e.e)
    begin
      err_total++;
      $display("BAD %0t read %h err %b exp %h", $time, prdata, pslverr, e.v);
    end
  endtask : chk_reg

  // One APB transfer; the request holds until ready is sampled high.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] dat);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    xfer(1'b1, a, dat);
  endtask : wr

  // The expectation is queued before the read leaves.
  task automatic rd(input logic [7:0] a, input logic [31:0] v,
                    input logic [31:0] m, input logic e);
    q.push_back('{v, m, e});
    xfer(1'b0, a, 32'h0);
  endtask : rd

  task automatic rst(input logic [3:0] straps);
    pf_drv <= {4'hF, straps};
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask : rst

  // Read data is judged at the completing edge against the oldest note.
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk_reg(q.pop_front());
  end

  initial
  begin
    rst(4'h0);
    chk_pin(mhost, 32'h0);
    rd(OFF_STRAPS, 32'h00, 32'h1F, 1'b0);
    pf_drv <= 8'hF4;
    repeat (4) @(posedge pclk);
    chk_pin(mhost, 32'h0);
    rd(OFF_FLAGIN, 32'hF4, 32'hFF, 1'b0);
    d = $random(seed) & 32'h00FFFFFF;
    wr(OFF_MEMDAT, d);
    wr(OFF_MEMREQ, 32'h6000_0005);
    repeat (6) @(posedge pclk);
    wr(OFF_MEMREQ, 32'h4000_0005);
    repeat (6) @(posedge pclk);
    rd(OFF_MEMDAT, d, 32'h00FFFFFF, 1'b0);
    wr(OFF_MEMREQ, 32'h8000_0003);
    repeat (6) @(posedge pclk);
    rd(8'h28, 32'h0, 32'hFFFFFFFF, 1'b1);
    ctx <= $random(seed);
    repeat (3) @(posedge pclk);
    chk_pin(tx, ctx);
    wr(OFF_SYSCTL, 32'h21);
    rx <= 1'b1;
    rfs_n <= 1'b0;
    repeat (3) @(posedge pclk);
    chk_pin(tx, 32'h1);
    chk_pin(afi, 32'h1);
    rd(OFF_ISTAT, 32'h10, 32'h10, 1'b0);
    wr(OFF_SYSCTL, 32'h0);
    repeat (3) @(posedge pclk);
    chk_pin(tx, ctx);
    eirq_n <= 1'b0;
    repeat (4) @(posedge pclk);
    eirq_n <= 1'b1;
    rd(OFF_ISTAT, 32'h1, 32'h1, 1'b0);
    chk_pin(irq, 32'h0);
    wr(OFF_IEN, 32'h1);
    repeat (3) @(posedge pclk);
    chk_pin(irq, 32'h1);
    wr(OFF_ICLR, 32'h1);
    repeat (3) @(posedge pclk);
    chk_pin(irq, 32'h0);
    wr(OFF_FLAGDIR, 32'h20);
    repeat (4) @(posedge pclk);
    rd(OFF_ISTAT, 32'h04, 32'h04, 1'b0);
    rd(OFF_FLAGIN, 32'h0, 32'h20, 1'b0);
    wr(OFF_IEN, 32'h4);
    repeat (3) @(posedge pclk);
    chk_pin(irq, 32'h1);
    wr(OFF_FLAGDIR, 32'h0);
    pf_drv[4] <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(OFF_ISTAT, 32'h08, 32'h08, 1'b0);
    wr(OFF_ICLR, 32'h0C);
    repeat (3) @(posedge pclk);
    rd(OFF_ISTAT, 32'h0, 32'h0C, 1'b0);
    pf_drv[4] <= 1'b1;
    breq_n <= 1'b0;
    for (int i = 0; i < 50 && bg_n !== 1'b0; i++) @(posedge pclk);
    chk_pin(bg_n, 32'h0);
    chk_pin(halt, 32'h1);
    breq_n <= 1'b1;
    for (int i = 0; i < 50 && bg_n !== 1'b1; i++) @(posedge pclk);
    chk_pin(bg_n, 32'h1);
    rst(4'h4);
    chk_pin(mhost, 32'h1);
    rd(OFF_STRAPS, 32'h14, 32'h1F, 1'b0);
    hsel_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chk_pin(ack_oe, 32'h1);
    hsel_n <= 1'b1;
    repeat (4) @(posedge pclk);
    chk_pin(ack_oe, 32'h0);
    end_of_test();
  end
endmodule : tb_dsp_pin_mode_mux
`default_nettype wire
